/* logic/lscsr_regs.sv */
// line-side configuration and status register bank behind the link command slots
//
// Notes on behaviour
// - config resets to f010: mutes, standard voltage
// - bits 15:14 rx attenuation 0/-6/-12/mute
// - bits 13:12 tx attenuation -20/-26/-32/mute
// - bit 11 picks fir or iir filters
// - bit 9 selects half or full wave
// - bit 7 selects fast or slow on-hook
// - billing enable detects tone, flags it
// - bit 5 selects real or complex termination
// - bits 4:3 dc termination, 00 reserved
// - bit 2 selects high or synthesized ringer
// - bit 0 selects ring threshold window
// - status resets to all zeros
// - status bit 10 disables charge pump
// - overload flag sticky, only with billing enabled
// - billing flag sticky, set when enabled
// - link error flag sticky until zero written
// - bit 6 shows link frame lock
// - bits 5:2 loop current in 6 mA
// - bits 1:0 show ring polarity activity
// - access via command slots, data returned
`timescale 1ns/1ps
module lscsr_regs
    import lscsr_pkg::*;
(
    // clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RESET_N,
    // command slot port from the link deframer
    input wire logic I_CMD_VALID,
    input wire logic I_CMD_READ,
    input wire logic [lscsr_pkg::ADDR_W-1:0] I_CMD_ADDR,
    input wire logic [lscsr_pkg::REG_W-1:0] I_CMD_WDATA,
    // status slot answer to the link framer
    output logic O_RSP_VALID,
    output logic [lscsr_pkg::ADDR_W-1:0] O_RSP_ADDR,
    output logic [lscsr_pkg::REG_W-1:0] O_RSP_RDATA,
    // line-side events and levels, asynchronous
    input wire logic I_RX_OVERLOAD,
    input wire logic I_BILL_TONE,
    input wire logic I_LINK_ERROR,
    input wire logic I_FRAME_LOCK,
    input wire logic [3:0] I_LOOP_CURRENT,
    input wire logic I_RING_POS,
    input wire logic I_RING_NEG,
    // controls to the analog front end
    output logic [1:0] O_RX_PATH_ATTEN,
    output logic [1:0] O_TX_PATH_ATTEN,
    output logic O_RECURSIVE_FILTER_SELECT,
    output logic O_RING_SQUELCH,
    output logic O_RING_FULL_WAVE,
    output logic O_ONHOOK_SPEED,
    output logic O_BILLING_DETECT_EN,
    output logic O_BILLING_HOLD_OFFHOOK,
    output logic O_AC_TERM_COMPLEX,
    output logic [1:0] O_DC_TERM_MODE,
    output logic O_DC_TERM_RESERVED,
    output logic O_RINGER_SYNTH,
    output logic O_RING_THRESHOLD_HIGH,
    output logic O_PUMP_DISABLE
);
    import lscsr_pkg::*;

    localparam int unsigned SYNC_W = 10;

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [REG_W-1:0] cfg;
        logic pump_disable;
        logic rx_overload_flag;
        logic billing_tone_flag;
        logic link_err_flag;
        logic rsp_valid;
        logic [ADDR_W-1:0] rsp_addr;
        logic [REG_W-1:0] rsp_rdata;
    } lscsr_state_t;

    lscsr_state_t st;
    lscsr_state_t next_st;

    logic [SYNC_W-1:0] line_async;
    logic [SYNC_W-1:0] line_sync;
    logic ovl_s;
    logic bill_s;
    logic lerr_s;
    logic frame_lock;
    logic [3:0] loop_current_level;
    logic ring_pos_active;
    logic ring_neg_active;
    logic wr_cfg;
    logic wr_sts;
    logic billing_detect_en;
    logic [REG_W-1:0] status_word;

    // -------------------------------------------------------------------
    // line-side inputs cross into the clock domain
    // -------------------------------------------------------------------
    assign line_async = {I_RX_OVERLOAD, I_BILL_TONE, I_LINK_ERROR, I_FRAME_LOCK,
                         I_LOOP_CURRENT, I_RING_POS, I_RING_NEG};

    lscsr_sync #(
        .W(SYNC_W)
    ) u_lscsr_sync (
        .i_clk(I_SYS_CLK),
        .i_reset_n(I_RESET_N),
        .i_async(line_async),
        .o_sync(line_sync)
    );

    assign {ovl_s, bill_s, lerr_s, frame_lock, loop_current_level, ring_pos_active, ring_neg_active} = line_sync;

    // -------------------------------------------------------------------
    // decode and readback
    // -------------------------------------------------------------------
    assign wr_cfg = I_CMD_VALID && !I_CMD_READ && (I_CMD_ADDR == LINE_CONFIG_ONE_OFS);
    assign wr_sts = I_CMD_VALID && !I_CMD_READ && (I_CMD_ADDR == LINE_STATUS_OFS);
    assign billing_detect_en = st.cfg[CFG_BILL_EN];

    always_comb begin
        status_word = '0;
        status_word[STS_PUMP_DIS] = st.pump_disable;
        status_word[STS_RX_OVL] = st.rx_overload_flag;
        status_word[STS_BILL] = st.billing_tone_flag;
        status_word[STS_LINK_ERR] = st.link_err_flag;
        status_word[STS_FRAME_LOCK] = frame_lock;
        status_word[STS_LOOP_HI:STS_LOOP_LO] = loop_current_level;
        status_word[STS_RING_POS] = ring_pos_active;
        status_word[STS_RING_NEG] = ring_neg_active;
    end

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (wr_cfg) begin
            next_st.cfg = I_CMD_WDATA & CFG_WR_MASK;
        end
        if (wr_sts) begin
            next_st.pump_disable = I_CMD_WDATA[STS_PUMP_DIS];
        end
        // clear only by written zero, a new event wins over the clear
        next_st.rx_overload_flag = (st.rx_overload_flag && !(wr_sts && !I_CMD_WDATA[STS_RX_OVL]))
                                   || (ovl_s && billing_detect_en);
        next_st.billing_tone_flag = (st.billing_tone_flag && !(wr_sts && !I_CMD_WDATA[STS_BILL]))
                                    || (bill_s && billing_detect_en);
        next_st.link_err_flag = (st.link_err_flag && !(wr_sts && !I_CMD_WDATA[STS_LINK_ERR]))
                                || lerr_s;
        // read answer for the matching input slots
        next_st.rsp_valid = I_CMD_VALID && I_CMD_READ;
        if (I_CMD_VALID && I_CMD_READ) begin
            next_st.rsp_addr = I_CMD_ADDR;
            if (I_CMD_ADDR == LINE_CONFIG_ONE_OFS) begin
                next_st.rsp_rdata = st.cfg;
            end else if (I_CMD_ADDR == LINE_STATUS_OFS) begin
                next_st.rsp_rdata = status_word;
            end else begin
                next_st.rsp_rdata = '0;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            st <= '0;
            st.cfg <= LINE_CONFIG_ONE_RST;
            st.pump_disable <= LINE_STATUS_RST[STS_PUMP_DIS];
        end else begin
            st <= next_st;
        end
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    assign O_RSP_VALID = st.rsp_valid;
    assign O_RSP_ADDR = st.rsp_addr;
    assign O_RSP_RDATA = st.rsp_rdata;
    assign O_RX_PATH_ATTEN = st.cfg[CFG_RX_ATTEN_HI:CFG_RX_ATTEN_LO];
    assign O_TX_PATH_ATTEN = st.cfg[CFG_TX_ATTEN_HI:CFG_TX_ATTEN_LO];
    assign O_RECURSIVE_FILTER_SELECT = st.cfg[CFG_FILTER];
    // squelch comes straight from stored config bit 10, held until the next config write
    assign O_RING_SQUELCH = st.cfg[CFG_SQUELCH];
    assign O_RING_FULL_WAVE = st.cfg[CFG_FULL_WAVE];
    assign O_ONHOOK_SPEED = st.cfg[CFG_ONHOOK];
    assign O_BILLING_DETECT_EN = billing_detect_en;
    assign O_BILLING_HOLD_OFFHOOK = billing_detect_en && bill_s;
    assign O_AC_TERM_COMPLEX = st.cfg[CFG_AC_TERM];
    assign O_DC_TERM_MODE = st.cfg[CFG_DC_HI:CFG_DC_LO];
    assign O_DC_TERM_RESERVED = (st.cfg[CFG_DC_HI:CFG_DC_LO] == LSCSR_DC_RSVD);
    assign O_RINGER_SYNTH = st.cfg[CFG_RINGER];
    assign O_RING_THRESHOLD_HIGH = st.cfg[CFG_THRESH];
    assign O_PUMP_DISABLE = st.pump_disable;

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RESET_N);

    sequence s_read_cfg;
        I_CMD_VALID && I_CMD_READ && (I_CMD_ADDR == LINE_CONFIG_ONE_OFS);
    endsequence

    a_cfg_write_lands: assert property (wr_cfg |=> st.cfg == ($past(I_CMD_WDATA) & CFG_WR_MASK))
        else $error("config write not stored");
    a_cfg_read_back: assert property (s_read_cfg |=> O_RSP_VALID && O_RSP_RDATA == $past(st.cfg))
        else $error("config readback wrong");
    a_rx_atten_map: assert property (wr_cfg |=>
        O_RX_PATH_ATTEN == $past(I_CMD_WDATA[CFG_RX_ATTEN_HI:CFG_RX_ATTEN_LO])
        && O_TX_PATH_ATTEN == $past(I_CMD_WDATA[CFG_TX_ATTEN_HI:CFG_TX_ATTEN_LO]))
        else $error("attenuation field misrouted");
    a_ovl_needs_en: assert property ($rose(st.rx_overload_flag) |-> $past(billing_detect_en))
        else $error("overload set without billing enable");
    a_bill_needs_en: assert property ($rose(st.billing_tone_flag) |-> $past(billing_detect_en && bill_s))
        else $error("billing flag set without cause");
    a_lerr_sticky: assert property (st.link_err_flag && !(wr_sts && !I_CMD_WDATA[STS_LINK_ERR])
                                    |=> st.link_err_flag)
        else $error("link error flag dropped");
    a_one_keeps: assert property (wr_sts && I_CMD_WDATA[STS_BILL] && !billing_detect_en && !st.billing_tone_flag
                                  |=> !st.billing_tone_flag)
        else $error("writing one set a flag");
    a_pump_ctrl: assert property (wr_sts |=> O_PUMP_DISABLE == $past(I_CMD_WDATA[STS_PUMP_DIS]))
        else $error("pump disable not updated");
    a_lock_live: assert property (st.rsp_valid && $past(I_CMD_ADDR) == LINE_STATUS_OFS
                                  |-> O_RSP_RDATA[STS_FRAME_LOCK] == $past(frame_lock))
        else $error("frame lock readback wrong");

    // reset values
    a_reset_cfg: assert property ($rose(I_RESET_N) |->
        st.cfg == LINE_CONFIG_ONE_RST)
        else $error("config reset value wrong");
    a_reset_mutes: assert property ($rose(I_RESET_N) |->
        O_RX_PATH_ATTEN == LSCSR_RX_MUTE && O_TX_PATH_ATTEN == LSCSR_TX_MUTE)
        else $error("paths not muted after reset");
    a_reset_dc_mode: assert property ($rose(I_RESET_N) |->
        O_DC_TERM_MODE == LSCSR_DC_STD_V && !O_DC_TERM_RESERVED)
        else $error("dc mode wrong after reset");
    a_reset_status: assert property ($rose(I_RESET_N) |->
        status_word == LINE_STATUS_RST && !O_RSP_VALID)
        else $error("status reset value wrong");

    // config fields follow a write
    a_filter_select: assert property (wr_cfg |=>
        O_RECURSIVE_FILTER_SELECT == $past(I_CMD_WDATA[CFG_FILTER]))
        else $error("filter select not stored");
    a_squelch_store: assert property (wr_cfg |=>
        O_RING_SQUELCH == $past(I_CMD_WDATA[CFG_SQUELCH]))
        else $error("squelch not stored");
    a_full_wave: assert property (wr_cfg |=>
        O_RING_FULL_WAVE == $past(I_CMD_WDATA[CFG_FULL_WAVE]))
        else $error("rectifier select not stored");
    a_onhook_speed: assert property (wr_cfg |=>
        O_ONHOOK_SPEED == $past(I_CMD_WDATA[CFG_ONHOOK]))
        else $error("on-hook speed not stored");
    a_bill_enable: assert property (wr_cfg |=>
        O_BILLING_DETECT_EN == $past(I_CMD_WDATA[CFG_BILL_EN]))
        else $error("billing enable not stored");
    a_ac_term: assert property (wr_cfg |=>
        O_AC_TERM_COMPLEX == $past(I_CMD_WDATA[CFG_AC_TERM]))
        else $error("ac termination not stored");
    a_dc_mode: assert property (wr_cfg |=>
        O_DC_TERM_MODE == $past(I_CMD_WDATA[CFG_DC_HI:CFG_DC_LO]))
        else $error("dc mode not stored");
    a_dc_reserved: assert property (wr_cfg |=>
        O_DC_TERM_RESERVED == ($past(I_CMD_WDATA[CFG_DC_HI:CFG_DC_LO]) == LSCSR_DC_RSVD))
        else $error("reserved dc code not flagged");
    a_ringer_synth: assert property (wr_cfg |=>
        O_RINGER_SYNTH == $past(I_CMD_WDATA[CFG_RINGER]))
        else $error("ringer select not stored");
    a_ring_thresh: assert property (wr_cfg |=>
        O_RING_THRESHOLD_HIGH == $past(I_CMD_WDATA[CFG_THRESH]))
        else $error("ring threshold not stored");
    a_cfg_holds: assert property (!wr_cfg |=> $stable(st.cfg))
        else $error("config changed without write");

    // read answers
    sequence s_read_any;
        I_CMD_VALID && I_CMD_READ;
    endsequence
    sequence s_read_sts;
        I_CMD_VALID && I_CMD_READ && (I_CMD_ADDR == LINE_STATUS_OFS);
    endsequence
    sequence s_read_other;
        I_CMD_VALID && I_CMD_READ && (I_CMD_ADDR != LINE_CONFIG_ONE_OFS) && (I_CMD_ADDR != LINE_STATUS_OFS);
    endsequence
    a_rsp_addr_echo: assert property (s_read_any |=>
        O_RSP_VALID && O_RSP_ADDR == $past(I_CMD_ADDR))
        else $error("read answer missing");
    a_sts_read_back: assert property (s_read_sts |=>
        O_RSP_RDATA == $past(status_word))
        else $error("status readback wrong");
    a_unmapped_zero: assert property (s_read_other |=>
        O_RSP_RDATA == '0)
        else $error("unmapped read not zero");
    a_rsp_quiet: assert property (!(I_CMD_VALID && I_CMD_READ) |=>
        !O_RSP_VALID && $stable(O_RSP_RDATA) && $stable(O_RSP_ADDR))
        else $error("answer changed without read");

    // sticky flags, set wins over a written zero
    sequence s_lerr_held;
        I_LINK_ERROR [*3];
    endsequence
    sequence s_ovl_enabled;
        (I_RX_OVERLOAD && billing_detect_en) [*3];
    endsequence
    sequence s_tone_enabled;
        (I_BILL_TONE && billing_detect_en) [*3];
    endsequence
    a_lerr_set: assert property (s_lerr_held |=>
        st.link_err_flag)
        else $error("link error not flagged");
    a_ovl_set: assert property (s_ovl_enabled |=>
        st.rx_overload_flag)
        else $error("overload not flagged");
    a_bill_set: assert property (s_tone_enabled |=>
        st.billing_tone_flag)
        else $error("billing tone not flagged");
    a_lerr_clear: assert property (wr_sts && !I_CMD_WDATA[STS_LINK_ERR]
        && !lerr_s |=> !st.link_err_flag)
        else $error("link error not cleared");
    a_ovl_clear: assert property (wr_sts && !I_CMD_WDATA[STS_RX_OVL]
        && !(ovl_s && billing_detect_en) |=> !st.rx_overload_flag)
        else $error("overload not cleared");
    a_ovl_sticky: assert property (st.rx_overload_flag
        && !(wr_sts && !I_CMD_WDATA[STS_RX_OVL]) |=> st.rx_overload_flag)
        else $error("overload flag dropped");
    a_bill_sticky: assert property (st.billing_tone_flag
        && !(wr_sts && !I_CMD_WDATA[STS_BILL]) |=> st.billing_tone_flag)
        else $error("billing flag dropped");
    a_hold_on_tone: assert property (s_tone_enabled |->
        O_BILLING_HOLD_OFFHOOK)
        else $error("off-hook not held through tone");
    a_pump_holds: assert property (!wr_sts |=> $stable(O_PUMP_DISABLE))
        else $error("pump disable changed without write");

    // synced levels shown in status, two cycles late
    a_lock_follows: assert property ($past(I_RESET_N, 2) && $past(I_RESET_N) |->
        status_word[STS_FRAME_LOCK] == $past(I_FRAME_LOCK, 2))
        else $error("frame lock bit wrong");
    a_loop_follows: assert property ($past(I_RESET_N, 2) && $past(I_RESET_N) |->
        status_word[STS_LOOP_HI:STS_LOOP_LO] == $past(I_LOOP_CURRENT, 2))
        else $error("loop current field wrong");
    a_ring_follows: assert property ($past(I_RESET_N, 2) && $past(I_RESET_N) |->
        status_word[STS_RING_POS] == $past(I_RING_POS, 2) && status_word[STS_RING_NEG] == $past(I_RING_NEG, 2))
        else $error("ring polarity bits wrong");
endmodule : lscsr_regs

/* pkg/lscsr_pkg.sv */
// register map, field layout and reset values of the line-side config/status bank
package lscsr_pkg;
    // -------------------------------------------------------------------
    // register offsets and widths
    // -------------------------------------------------------------------
    localparam int unsigned REG_W = 16;
    localparam int unsigned ADDR_W = 7;
    localparam logic [6:0] LINE_CONFIG_ONE_OFS = 7'h5c;
    localparam logic [6:0] LINE_STATUS_OFS = 7'h5e;
    localparam logic [15:0] LINE_CONFIG_ONE_RST = 16'hf010;
    localparam logic [15:0] LINE_STATUS_RST = 16'h0000;
    // -------------------------------------------------------------------
    // config field positions
    // -------------------------------------------------------------------
    localparam int unsigned CFG_RX_ATTEN_HI = 15;
    localparam int unsigned CFG_RX_ATTEN_LO = 14;
    localparam int unsigned CFG_TX_ATTEN_HI = 13;
    localparam int unsigned CFG_TX_ATTEN_LO = 12;
    localparam int unsigned CFG_FILTER = 11;
    localparam int unsigned CFG_SQUELCH = 10;
    localparam int unsigned CFG_FULL_WAVE = 9;
    localparam int unsigned CFG_ONHOOK = 7;
    localparam int unsigned CFG_BILL_EN = 6;
    localparam int unsigned CFG_AC_TERM = 5;
    localparam int unsigned CFG_DC_HI = 4;
    localparam int unsigned CFG_DC_LO = 3;
    localparam int unsigned CFG_RINGER = 2;
    localparam int unsigned CFG_THRESH = 0;
    // writable bits; reserved bits 8 and 1 read zero
    localparam logic [15:0] CFG_WR_MASK = 16'hfefd;
    // -------------------------------------------------------------------
    // status field positions
    // -------------------------------------------------------------------
    localparam int unsigned STS_PUMP_DIS = 10;
    localparam int unsigned STS_RX_OVL = 9;
    localparam int unsigned STS_BILL = 8;
    localparam int unsigned STS_LINK_ERR = 7;
    localparam int unsigned STS_FRAME_LOCK = 6;
    localparam int unsigned STS_LOOP_HI = 5;
    localparam int unsigned STS_LOOP_LO = 2;
    localparam int unsigned STS_RING_POS = 1;
    localparam int unsigned STS_RING_NEG = 0;
    // -------------------------------------------------------------------
    // encodings
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        LSCSR_RX_0DB = 2'h0,
        LSCSR_RX_M6DB = 2'h1,
        LSCSR_RX_M12DB = 2'h2,
        LSCSR_RX_MUTE = 2'h3
    } lscsr_rx_atten_t;
    typedef enum logic [1:0] {
        LSCSR_TX_M20DB = 2'h0,
        LSCSR_TX_M26DB = 2'h1,
        LSCSR_TX_M32DB = 2'h2,
        LSCSR_TX_MUTE = 2'h3
    } lscsr_tx_atten_t;
    typedef enum logic [1:0] {
        LSCSR_DC_RSVD = 2'h0,
        LSCSR_DC_LOW_V = 2'h1,
        LSCSR_DC_STD_V = 2'h2,
        LSCSR_DC_ILIM = 2'h3
    } lscsr_dc_mode_t;
endpackage : lscsr_pkg

/* logic/lscsr_sync.sv */
// two-flop synchroniser for a bus of line-side levels
`timescale 1ns/1ps
module lscsr_sync #(
    parameter int unsigned W = 8
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // levels
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] held;
    } lscsr_sync_state_t;

    lscsr_sync_state_t st;
    lscsr_sync_state_t next_st;

    always_comb begin
        next_st.meta = i_async;
        next_st.held = st.meta;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_sync = st.held;
endmodule : lscsr_sync

/* bench/lscsr_host.sv */
// host controller model driving the register command slots
`timescale 1ns/1ps
module lscsr_host
    import lscsr_pkg::*;
(
    // clock
    input wire logic i_clk,
    // command slot
    output logic o_cmd_valid = 1'b0,
    output logic o_cmd_read = 1'b0,
    output logic [lscsr_pkg::ADDR_W-1:0] o_cmd_addr = 7'h00,
    output logic [lscsr_pkg::REG_W-1:0] o_cmd_wdata = 16'h0000,
    // answer slot
    input wire logic i_rsp_valid,
    input wire logic [lscsr_pkg::ADDR_W-1:0] i_rsp_addr,
    input wire logic [lscsr_pkg::REG_W-1:0] i_rsp_rdata
);
    // -------------------------------------------------------------------
    // slot transfers; line side taken as powered before first use
    // -------------------------------------------------------------------
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge i_clk);
        #1;
        o_cmd_valid = 1'b1;
        o_cmd_read = 1'b0;
        o_cmd_addr = a;
        o_cmd_wdata = d;
        @(posedge i_clk);
        #1;
        o_cmd_valid = 1'b0;
        o_cmd_addr = ~a;
        o_cmd_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [6:0] a, output logic [15:0] d, output logic ok);
        @(posedge i_clk);
        #1;
        o_cmd_valid = 1'b1;
        o_cmd_read = 1'b1;
        o_cmd_addr = a;
        @(posedge i_clk);
        #1;
        o_cmd_valid = 1'b0;
        o_cmd_addr = ~a;
        o_cmd_wdata = ~o_cmd_wdata;
        ok = (i_rsp_valid === 1'b1) && (i_rsp_addr === a);
        d = i_rsp_rdata;
    endtask : rd
endmodule : lscsr_host

/* bench/line_side_config_status_regs_test.sv */
// self-checking bench of the line-side config/status bank
`timescale 1ns/1ps
module line_side_config_status_regs_test;
    import lscsr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ovl = 1'b0, tone = 1'b0, lerr = 1'b0, flock = 1'b0, rpos = 1'b0, rneg = 1'b0;
    logic [3:0] loop_i = 4'h0;
    logic e_pump = 1'b0, e_ov = 1'b0, e_bt = 1'b0, e_le = 1'b0;
    logic cv, cr, rv;
    logic [6:0] ca, ra;
    logic [15:0] cw, rd_data;
    logic [1:0] rx_a, tx_a, dc_m;
    logic filt, sq, fw, onh, ben, hold, ac_cx, dc_rsv, rsyn, thr, pump;
    logic [15:0] cfg_out;
    int fail_count = 0;
    int num_checks = 0;
    assign cfg_out = {rx_a, tx_a, filt, sq, fw, 1'b0, onh, ben, ac_cx, dc_m, rsyn, 1'b0, thr};
    always #2 clk = ~clk;
    // -------------------------------------------------------------------
    // design and host model
    // -------------------------------------------------------------------
    lscsr_regs u_lscsr_regs (.I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_CMD_VALID(cv), .I_CMD_READ(cr),
        .I_CMD_ADDR(ca), .I_CMD_WDATA(cw), .O_RSP_VALID(rv), .O_RSP_ADDR(ra), .O_RSP_RDATA(rd_data),
        .I_RX_OVERLOAD(ovl), .I_BILL_TONE(tone), .I_LINK_ERROR(lerr), .I_FRAME_LOCK(flock),
        .I_LOOP_CURRENT(loop_i), .I_RING_POS(rpos), .I_RING_NEG(rneg), .O_RX_PATH_ATTEN(rx_a),
        .O_TX_PATH_ATTEN(tx_a), .O_RECURSIVE_FILTER_SELECT(filt), .O_RING_SQUELCH(sq),
        .O_RING_FULL_WAVE(fw), .O_ONHOOK_SPEED(onh), .O_BILLING_DETECT_EN(ben),
        .O_BILLING_HOLD_OFFHOOK(hold), .O_AC_TERM_COMPLEX(ac_cx), .O_DC_TERM_MODE(dc_m),
        .O_DC_TERM_RESERVED(dc_rsv), .O_RINGER_SYNTH(rsyn), .O_RING_THRESHOLD_HIGH(thr),
        .O_PUMP_DISABLE(pump));
    lscsr_host u_lscsr_host (.i_clk(clk), .o_cmd_valid(cv), .o_cmd_read(cr), .o_cmd_addr(ca),
        .o_cmd_wdata(cw), .i_rsp_valid(rv), .i_rsp_addr(ra), .i_rsp_rdata(rd_data));
    // -------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------
    task automatic final_report;
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic rdchk(input logic [6:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        u_lscsr_host.rd(a, d, ok);
        if (ok !== 1'b1) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, ok, 1'b1);
        end
        check(d, exp);
    endtask : rdchk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    function automatic logic [15:0] sts();
        return {5'h00, e_pump, e_ov, e_bt, e_le, flock, loop_i, rpos, rneg};
    endfunction : sts
    // -------------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------------
    task automatic t_reset;
        rdchk(LINE_CONFIG_ONE_OFS, 16'hf010);
        check(cfg_out, 16'hf010);
        rdchk(LINE_STATUS_OFS, 16'h0000);
    endtask : t_reset

    task automatic t_cfg;
        // squelch set by 5555, cleared by aaaa
        logic [15:0] pat [4] = '{16'h0000, 16'h5555, 16'haaaa, 16'hffff};
        foreach (pat[i]) begin
            u_lscsr_host.wr(LINE_CONFIG_ONE_OFS, pat[i]);
            check(cfg_out, pat[i] & 16'hfefd);
            check(16'(dc_rsv), 16'(pat[i][4:3] == 2'h0));
            rdchk(LINE_CONFIG_ONE_OFS, pat[i] & 16'hfefd);
        end
        u_lscsr_host.wr(7'h5a, 16'h0000);
        rdchk(LINE_CONFIG_ONE_OFS, 16'hfefd);
        rdchk(7'h5a, 16'h0000);
    endtask : t_cfg

    task automatic t_flags;
        u_lscsr_host.wr(LINE_CONFIG_ONE_OFS, 16'h0000);
        ovl = 1'b1;
        tone = 1'b1;
        lerr = 1'b1;
        cyc(4);
        e_le = 1'b1;
        check(16'(hold), 16'h0000);
        rdchk(LINE_STATUS_OFS, sts());
        ovl = 1'b0;
        tone = 1'b0;
        lerr = 1'b0;
        cyc(4);
        u_lscsr_host.wr(LINE_STATUS_OFS, 16'h0380);
        rdchk(LINE_STATUS_OFS, sts());
        u_lscsr_host.wr(LINE_STATUS_OFS, 16'h0000);
        e_le = 1'b0;
        rdchk(LINE_STATUS_OFS, sts());
        u_lscsr_host.wr(LINE_CONFIG_ONE_OFS, 16'h0040);
        ovl = 1'b1;
        tone = 1'b1;
        cyc(4);
        e_ov = 1'b1;
        e_bt = 1'b1;
        check(16'(hold), 16'h0001);
        // zero written while the events persist: set wins
        u_lscsr_host.wr(LINE_STATUS_OFS, 16'h0000);
        rdchk(LINE_STATUS_OFS, sts());
        ovl = 1'b0;
        tone = 1'b0;
        cyc(4);
        check(16'(hold), 16'h0000);
        rdchk(LINE_STATUS_OFS, sts());
        u_lscsr_host.wr(LINE_STATUS_OFS, 16'h0000);
        e_ov = 1'b0;
        e_bt = 1'b0;
        rdchk(LINE_STATUS_OFS, sts());
    endtask : t_flags

    task automatic t_levels;
        flock = 1'b1;
        loop_i = 4'hf;
        rpos = 1'b1;
        cyc(4);
        rdchk(LINE_STATUS_OFS, sts());
        u_lscsr_host.wr(LINE_STATUS_OFS, 16'hffff);
        e_pump = 1'b1;
        check(16'(pump), 16'h0001);
        rdchk(LINE_STATUS_OFS, sts());
        flock = 1'b0;
        loop_i = 4'h5;
        rpos = 1'b0;
        rneg = 1'b1;
        cyc(4);
        u_lscsr_host.wr(LINE_STATUS_OFS, 16'h0000);
        e_pump = 1'b0;
        check(16'(pump), 16'h0000);
        rdchk(LINE_STATUS_OFS, sts());
    endtask : t_levels
    // -------------------------------------------------------------------
    // main sequence and watchdog
    // -------------------------------------------------------------------
    initial begin
        cyc(6);
        rst_n = 1'b1;
        t_reset();
        t_cfg();
        t_flags();
        t_levels();
        // reset again in mid-run with quiet line levels
        loop_i = 4'h0;
        rneg = 1'b0;
        rst_n = 1'b0;
        cyc(6);
        rst_n = 1'b1;
        t_reset();
        final_report();
    end

    initial begin
        #200000;
        fail_count++;
        final_report();
    end
endmodule : line_side_config_status_regs_test
